// file: tb_top.sv
// self-checking bench: source and loopback partner around the framer
// assumes the partner feeds encoder output straight back to the receiver
`timescale 1ns/1ps
module tb_top;
   localparam int PKT = 1504;
   logic       clock = 1'b0;
   logic       resetn = 1'b1;
   logic       bypass = 1'b0;
   logic       markPrevious = 1'b1;
   logic       enable = 1'b0;
   logic       corrupt = 1'b0;
   logic [7:0] fecFirst = 8'h00;
   int         fails = 0;
   int         nCompared = 0;
   int         peCount, osCount, oeCount;
   wire        tsData, tsValid, tsStart, fecData, fecValid, rxData, rxValid;
   wire        outData, outValid, outStart, outError, packetError, locked;

   always #2.5 clock = ~clock;

   // short lock and miss runs keep the run brief
   ts_packet_sync_checksum #(.LOCK_N(4'h2), .MISS_N(4'h2)) i_dut (.*);
   ts_stream_partner i_partner (.*);

   always @(posedge clock)
   begin
      peCount <= peCount + packetError;
      osCount <= osCount + outStart;
      oeCount <= oeCount + (outError && outValid);
      if (fecValid)
         fecFirst <= {fecFirst[6:0], fecData};
   end

   task automatic check(input string name, input logic [31:0] seen, exp);
      nCompared++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic conclude;
      $display("compared %0d mismatched %0d", nCompared, fails);
      if (fails == 0 && nCompared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic clear;
      peCount = 0;
      osCount = 0;
      oeCount = 0;
   endtask

   task automatic runPkts(input int n);
      repeat (n * PKT) @(negedge clock);
   endtask

   task automatic waitLock(input logic want, input int limit);
      for (int i = 0; i < limit && locked !== want; i++)
         @(negedge clock);
      check("locked", 32'(locked), 32'(want));
      if (locked !== want)
         conclude();
   endtask

   // non-blocking, so the partner's falling-edge process never races the bench
   task automatic resetDut(input logic byp);
      resetn <= 1'b0;
      bypass <= byp;
      enable <= 1'b0;
      corrupt <= 1'b0;
      repeat (4) @(negedge clock);
      check("reset outputs", {26'h0, fecValid, outValid, outStart, outError, packetError, locked}, 32'h0);
      resetn <= 1'b1;
   endtask

   task automatic lockScenario;
      enable <= 1'b1;
      // one edge to the partner, one through the encoder, eight bits
      repeat (10) @(negedge clock);
      check("first sync", 32'(fecFirst), 32'h47);
      // false syndrome hits while hunting stretch the search
      waitLock(1'b1, 24 * PKT);
      clear();
      runPkts(3);
      check("misses", peCount, 0);
      check("sync bytes", osCount, 3);
      check("marked bits", oeCount, 0);
   endtask

   task automatic errorScenario;
      clear();
      corrupt <= 1'b1;
      runPkts(1);
      corrupt <= 1'b0;
      runPkts(2);
      check("single miss", peCount, 1);
      check("lock kept", 32'(locked), 1);
      check("marked packet", oeCount, PKT);
   endtask

   task automatic unlockScenario;
      clear();
      markPrevious <= 1'b0;
      corrupt <= 1'b1;
      runPkts(2);
      waitLock(1'b0, PKT);
      corrupt <= 1'b0;
      waitLock(1'b1, 24 * PKT);
      check("two misses", peCount, 2);
      check("unmarked", oeCount, 0);
   endtask

   task automatic bypassScenario;
      resetDut(1'b1);
      enable <= 1'b1;
      corrupt <= 1'b1;
      clear();
      runPkts(2);
      check("bypass lock", 32'(locked), 0);
      check("bypass errors", peCount, 0);
   endtask

   initial
   begin
      resetDut(1'b0);
      lockScenario();
      errorScenario();
      unlockScenario();
      bypassScenario();
      conclude();
   end
endmodule // tb_top

// file: ts_checksum_gen.v
// checksum generator: 1/g(X) divider, eight zero shifts, g(X) FIR, offset
// assumes clear and shift are never asserted together by the caller
`timescale 1ns/1ps

`include "ts_sync_map.vh"

module ts_checksum_gen
#(
   parameter [7:0] OFFSET = `CS_OFFSET
)
(
   // clock and reset
   input  wire       clock,
   input  wire       resetn,
   // control
   input  wire       clear,
   input  wire       shift,
   input  wire       dataIn,
   // result, valid once the payload has been absorbed
   output wire [7:0] checksum
);

   reg  [7:0] iirReg;
   reg  [6:0] headReg;
   reg  [2:0] headCnt;
   wire       fbBit;

   // g = 1 + X + X^5 + X^6 + X^8; bit k-1 holds y[n-k]
   assign fbBit = dataIn ^ iirReg[0] ^ iirReg[4] ^ iirReg[5] ^ iirReg[7];

   // zero-input shifts and FIR unrolled, so the byte is ready one bit later
   function [7:0] finish;
      input [7:0] state;
      input [6:0] head;
      reg   [7:0] st;
      reg   [7:0] fir;
      reg   [7:0] res;
      reg         y;
      reg         z;
      integer     i;
      begin
         st  = state;
         fir = 8'h00;
         res = 8'h00;
         for (i = 0; i < 8; i = i + 1)
         begin
            y   = st[0] ^ st[4] ^ st[5] ^ st[7];
            st  = {st[6:0], y};
            z   = y ^ fir[0] ^ fir[4] ^ fir[5] ^ fir[7];
            fir = {fir[6:0], y};
            res = {res[6:0], z};
         end
         // X^1497 b(X) feed-forward still reaches the first seven payload bits
         finish = res ^ OFFSET
                ^ {1'b0, head} ^ {2'b00, head[6:1]} ^ {4'h0, head[6:3]};
      end
   endfunction

   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         iirReg  <= 8'h00;
         headReg <= 7'h00;
         headCnt <= 3'h0;
      end
      else if (clear)
      begin
         iirReg  <= 8'h00;
         headReg <= 7'h00;
         headCnt <= 3'h0;
      end
      else if (shift)
      begin
         iirReg <= {iirReg[6:0], fbBit};
         if (headCnt != 3'h7)
         begin
            headReg <= {headReg[5:0], dataIn};
            headCnt <= headCnt + 3'h1;
         end
      end
   end

   assign checksum = finish(iirReg, headReg);

endmodule // ts_checksum_gen

// file: ts_packet_sync_checksum.v
// transport packet framer: checksum insertion on transmit, sliding-checksum
// packet delineation, error flagging and sync restore on receive
// assumes one bit per valid strobe on each stream and static configuration
// Summary of operation
// - packets are 188 bytes, continuous stream
// - serial bits, most significant bit first
// - encoder replaces sync with checksum of predecessor
// - checksum from feedback divider over 1496 bits
// - divider cleared before each payload
// - eight zero-input shifts yield syndrome bits
// - syndrome bits pass zero-initialised g FIR
// - raw checksum offset by 67
// - checksum sent MSB first after payload
// - sliding checksum finds packet boundaries
// - locked decoder flags missing code word
// - optionally mark preceding packet erroneous on output
// - decoder restores sync byte over checksum
// - syndrome over 187 bytes plus checksum
// - valid exactly when syndrome equals 47
// - syndrome by generator structure, zero offset
// - check matrix: eight shifted copies, zero fill
// - non-transport traffic bypasses framing entirely
`timescale 1ns/1ps

`include "ts_sync_map.vh"

module ts_packet_sync_checksum
#(
   parameter [3:0] LOCK_N = `LOCK_COUNT,
   parameter [3:0] MISS_N = `MISS_COUNT
)
(
   // clock and reset
   input  wire clock,
   input  wire resetn,
   // static configuration
   input  wire bypass,
   input  wire markPrevious,
   // transmit: transport stream in
   input  wire tsData,
   input  wire tsValid,
   input  wire tsStart,
   // transmit: to error-correction layer
   output wire fecData,
   output wire fecValid,
   // receive: from error-correction layer
   input  wire rxData,
   input  wire rxValid,
   // receive: transport stream out
   output wire outData,
   output wire outValid,
   output wire outStart,
   output wire outError,
   output wire packetError,
   output wire locked
);

   localparam [2:0] ST_HUNT    = 3'b001;
   localparam [2:0] ST_CONFIRM = 3'b010;
   localparam [2:0] ST_LOCK    = 3'b100;

   // ---------------- transmit ----------------
   reg  [10:0] encPosReg;
   reg         encAlignedReg;
   reg         csGoodReg;
   reg  [7:0]  csReg;
   reg         fecDataReg;
   reg         fecValidReg;
   wire [10:0] encCur;
   wire        encAligned;
   wire        encSync;
   wire        genClear;
   wire        genShift;
   wire [7:0]  csNow;
   wire        csBit;
   wire        encBit;

   assign encCur     = tsStart ? 11'd0 : encPosReg;
   assign encAligned = encAlignedReg | tsStart;
   assign encSync    = encCur < `SYNC_BITS;
   // clear lands on the first sync bit, after the finished byte was taken
   assign genClear   = tsValid & encAligned & ~bypass & (encCur == 11'd0);
   assign genShift   = tsValid & encAligned & ~bypass & ~encSync;

   ts_checksum_gen
   #(
      .OFFSET   (`CS_OFFSET)
   )
   u_gen
   (
      .clock    (clock),
      .resetn   (resetn),
      .clear    (genClear),
      .shift    (genShift),
      .dataIn   (tsData),
      .checksum (csNow)
   );

   // first bit straight from the generator, the rest from the latch
   assign csBit  = (encCur == 11'd0) ? csNow[7] : csReg[3'd7 - encCur[2:0]];
   // first packet after alignment has no predecessor: its sync goes through
   assign encBit = (!bypass && encAligned && encSync && csGoodReg) ? csBit : tsData;

   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         encPosReg     <= 11'd0;
         encAlignedReg <= 1'b0;
         csGoodReg     <= 1'b0;
         csReg         <= 8'h00;
         fecDataReg    <= 1'b0;
         fecValidReg   <= 1'b0;
      end
      else
      begin
         fecValidReg <= tsValid;
         if (tsValid)
         begin
            fecDataReg <= bypass ? tsData : encBit;
            if (tsStart)
               encAlignedReg <= 1'b1;
            // a start marker out of place discards the running checksum
            if (tsStart && encPosReg != 11'd0)
               csGoodReg <= 1'b0;
            else if (encAligned && encCur == `PKT_LAST)
               csGoodReg <= 1'b1;
            if (encCur == 11'd0)
               csReg <= csNow;
            encPosReg <= (encCur == `PKT_LAST) ? 11'd0 : encCur + 11'd1;
         end
      end
   end

   assign fecData  = fecDataReg;
   assign fecValid = fecValidReg;

   // ---------------- receive ----------------
   reg  [`HIST_LEN-1:0] histReg;
   reg  [6:0]           syndReg;
   reg  [7:0]           divReg;
   reg  [10:0]          posReg;
   reg  [2:0]           stateReg;
   reg  [2:0]           stateNext;
   reg  [3:0]           cntReg;
   reg  [3:0]           cntNext;
   reg                  realign;
   reg                  errPulse;
   reg                  outDataReg;
   reg                  outValidReg;
   reg                  outStartReg;
   reg                  outErrorReg;
   reg                  pktErrReg;
   reg                  packetErrorReg;
   wire                 slideBit;
   wire                 feedBit;
   wire [7:0]           syndrome;
   wire                 match;
   wire                 atBoundary;
   wire                 inSync;
   wire                 restoreBit;

   // taps then 1/g: g divides the numerator, so this is the 1497-bit check column
   // history and divider both start at zero, which keeps the quotient exact
   assign feedBit  = rxData ^ histReg[`TAP_B0] ^ histReg[`TAP_B1]
                   ^ histReg[`TAP_B3] ^ histReg[`TAP_B7];
   assign slideBit = feedBit ^ divReg[0] ^ divReg[4] ^ divReg[5] ^ divReg[7];
   // window of 187 bytes plus checksum, one bit per shifted check column
   assign syndrome = {syndReg, slideBit};
   assign match    = (syndrome == `SYNC_BYTE);
   assign atBoundary = (posReg == `PKT_LAST);
   assign inSync   = (posReg >= `PAY_BITS);
   // PAY_BITS is a multiple of eight, so the low bits index the sync byte
   assign restoreBit = |(`SYNC_BYTE & (8'h80 >> posReg[2:0]));

   always @*
   begin
      stateNext = stateReg;
      cntNext   = cntReg;
      realign   = 1'b0;
      errPulse  = 1'b0;
      case (stateReg)
         ST_HUNT:
         begin
            if (match)
            begin
               realign = 1'b1;
               cntNext = 4'd1;
               stateNext = (LOCK_N <= 4'd1) ? ST_LOCK : ST_CONFIRM;
               if (LOCK_N <= 4'd1)
                  cntNext = 4'd0;
            end
         end
         ST_CONFIRM:
         begin
            if (atBoundary)
            begin
               if (!match)
               begin
                  stateNext = ST_HUNT;
                  cntNext   = 4'd0;
               end
               else if (cntReg + 4'd1 >= LOCK_N)
               begin
                  stateNext = ST_LOCK;
                  cntNext   = 4'd0;
               end
               else
                  cntNext = cntReg + 4'd1;
            end
         end
         ST_LOCK:
         begin
            if (atBoundary)
            begin
               if (match)
                  cntNext = 4'd0;
               else
               begin
                  errPulse = 1'b1;
                  if (cntReg + 4'd1 >= MISS_N)
                  begin
                     stateNext = ST_HUNT;
                     cntNext   = 4'd0;
                  end
                  else
                     cntNext = cntReg + 4'd1;
               end
            end
         end
         default:
         begin
            stateNext = ST_HUNT;
            cntNext   = 4'd0;
         end
      endcase
   end

   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         histReg        <= {`HIST_LEN{1'b0}};
         syndReg        <= 7'h00;
         divReg         <= 8'h00;
         posReg         <= 11'd0;
         stateReg       <= ST_HUNT;
         cntReg         <= 4'd0;
         pktErrReg      <= 1'b0;
         outDataReg     <= 1'b0;
         outValidReg    <= 1'b0;
         outStartReg    <= 1'b0;
         outErrorReg    <= 1'b0;
         packetErrorReg <= 1'b0;
      end
      else if (bypass)
      begin
         // straight through, framing state parked so it restarts cleanly
         outDataReg     <= rxData;
         outValidReg    <= rxValid;
         outStartReg    <= 1'b0;
         outErrorReg    <= 1'b0;
         packetErrorReg <= 1'b0;
         stateReg       <= ST_HUNT;
         cntReg         <= 4'd0;
         pktErrReg      <= 1'b0;
      end
      else
      begin
         outValidReg    <= rxValid;
         outStartReg    <= 1'b0;
         packetErrorReg <= 1'b0;
         if (rxValid)
         begin
            histReg  <= {histReg[`HIST_LEN-2:0], rxData};
            syndReg  <= syndrome[6:0];
            divReg   <= {divReg[6:0], slideBit};
            stateReg <= stateNext;
            cntReg   <= cntNext;
            packetErrorReg <= errPulse;
            // output lags the input one whole packet so the verdict precedes it
            if (stateReg != ST_HUNT && inSync)
               outDataReg <= restoreBit;
            else
               outDataReg <= histReg[`HIST_LEN-1];
            outStartReg <= (stateReg != ST_HUNT) && (posReg == `PAY_BITS);
            outErrorReg <= pktErrReg & markPrevious;
            if (realign || atBoundary)
            begin
               posReg    <= 11'd0;
               pktErrReg <= errPulse;
            end
            else
               posReg <= posReg + 11'd1;
         end
      end
   end

   assign outData     = outDataReg;
   assign outValid    = outValidReg;
   assign outStart    = outStartReg;
   assign outError    = outErrorReg;
   assign packetError = packetErrorReg;
   assign locked      = (stateReg == ST_LOCK);

endmodule // ts_packet_sync_checksum

// file: ts_packet_sync_checksum_asserts.sv
// port assertions for the transport packet framer
// assumes one clock domain with resetn as its only reset
`timescale 1ns/1ps
`include "ts_sync_map.vh"
module ts_packet_sync_checksum_asserts
#(
   parameter [3:0] LOCK_N = `LOCK_COUNT,
   parameter [3:0] MISS_N = `MISS_COUNT
)
(
   // clock, reset and configuration
   input wire clock, resetn, bypass, markPrevious,
   // transmit
   input wire tsData, tsValid, tsStart, fecData, fecValid,
   // receive
   input wire rxData, rxValid, outData, outValid, outStart, outError, packetError, locked
);
   localparam [7:0] SYNC = `SYNC_BYTE;
   reg  [10:0] txPos;
   reg  [2:0]  syncPos;
   reg         inSync;
   wire [10:0] txCur   = tsStart ? 11'h000 : txPos;
   wire [2:0]  syncIdx = outStart ? 3'h0 : syncPos;

   default clocking dc @(posedge clock); endclocking
   default disable iff (!resetn);

   // sync tracking lives for eight strobes only
   always @(posedge clock or negedge resetn)
      if (!resetn)
      begin
         txPos   <= 11'h000;
         syncPos <= 3'h0;
         inSync  <= 1'b0;
      end
      else
      begin
         if (tsValid)
            txPos <= txCur + 11'h001;
         if (outValid)
         begin
            syncPos <= syncIdx + 3'h1;
            inSync  <= outStart || (inSync && syncPos != 3'h7);
         end
      end

   sequence lockRise;
      !locked ##1 locked;
   endsequence
   sequence lockHeld;
      locked [*8];
   endsequence

   fec_strobe_a: assert property (1'b1 |=> fecValid == $past(tsValid))
      else $error("fecValid lag wrong");
   payload_pass_a: assert property (tsValid && txCur >= `SYNC_BITS |=> fecData == $past(tsData))
      else $error("payload bit altered");
   bypass_pass_a: assert property (bypass && tsValid |=> fecData == $past(tsData))
      else $error("bypass bit altered");
   bypass_quiet_a: assert property (bypass |-> !(packetError || locked || outError))
      else $error("flags in bypass");
   bypass_rx_a: assert property (bypass && rxValid |=> outData == $past(rxData))
      else $error("bypass receive bit altered");
   out_strobe_a: assert property (rxValid |=> outValid)
      else $error("outValid missing");
   sync_restore_a: assert property (outValid && (outStart || inSync) |-> outData == SYNC[3'h7 - syncIdx])
      else $error("sync bit wrong");
   error_locked_a: assert property (packetError |-> $past(locked))
      else $error("error while unlocked");
   error_pulse_a: assert property (packetError |=> !packetError [*8])
      else $error("error pulse too long");
   lock_hold_a: assert property (lockRise |=> lockHeld)
      else $error("lock dropped early");
   mark_option_a: assert property (outError |-> markPrevious)
      else $error("outError without option");
endmodule // ts_packet_sync_checksum_asserts

bind ts_packet_sync_checksum ts_packet_sync_checksum_asserts #(.LOCK_N(LOCK_N), .MISS_N(MISS_N)) i_checks (.*);

// file: ts_stream_partner.sv
// transport source and error-correction loopback around the framer
// assumes the framer samples on rising edges; all changes here at falling
`timescale 1ns/1ps
`include "ts_sync_map.vh"
module ts_stream_partner
(
   // clock, reset and bench control
   input  wire  clock,
   input  wire  resetn,
   input  wire  enable,
   input  wire  corrupt,
   // transport source
   output logic tsData,
   output logic tsValid,
   output logic tsStart,
   // loopback
   input  wire  fecData,
   input  wire  fecValid,
   output logic rxData,
   output logic rxValid
);
   localparam [7:0] SYNC = `SYNC_BYTE;
   logic [10:0] bitPos;
   logic [7:0]  pktNum;

   always @(negedge clock or negedge resetn)
      if (!resetn)
      begin
         {bitPos, pktNum, tsData, tsValid, tsStart, rxData, rxValid} <= '0;
      end
      else
      begin
         tsValid <= enable;
         tsStart <= enable && bitPos == 11'h000;
         if (!enable)
            tsData <= ~tsData;
         else if (bitPos < `SYNC_BITS)
            tsData <= SYNC[3'h7 - bitPos[2:0]];
         else
            tsData <= ^(bitPos[7:0] & pktNum) ^ bitPos[2];
         if (enable)
         begin
            bitPos <= (bitPos == `PKT_LAST) ? 11'h000 : bitPos + 11'h001;
            pktNum <= pktNum + {7'h00, bitPos == `PKT_LAST};
         end
         // only the first bit of the sync slot (the checksum msb unless bypassed) is ever flipped, and only on request
         rxValid <= fecValid;
         rxData  <= fecValid ? fecData ^ (corrupt && bitPos == 11'h001) : ~rxData;
      end
endmodule // ts_stream_partner

// file: ts_sync_map.vh
// constants of the transport packet sync/checksum framer
// assumes the includer handles one serial bit per valid strobe
`ifndef TS_SYNC_MAP_VH
`define TS_SYNC_MAP_VH

// packet geometry in bits
`define PKT_BITS        11'd1504
`define PKT_LAST        11'd1503
`define PAY_BITS        11'd1496
`define SYNC_BITS       11'd8

// constant sync value and checksum offset
`define SYNC_BYTE       8'h47
`define CS_OFFSET       8'h67

// sliding history length and the X^1497*b(X) tap positions
`define HIST_LEN        1504
`define TAP_B0          1496
`define TAP_B1          1497
`define TAP_B3          1499
`define TAP_B7          1503

// lock defaults
`define LOCK_COUNT      4'h3
`define MISS_COUNT      4'h3

`endif
